// ---- pcr_pkg.sv ----
// constants, field positions and command kinds for the card reader controller
// assumes status and command words are numbered msb-first: bit 0 is word[15]
package pcr_pkg;
    localparam int CLK_MHZ = 125;
    localparam int PICK_MIN_NS = 1000;
    localparam int PICK_MIN_CYC = (PICK_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int ROWS = 12;
    // status word positions (printed bit n sits at index 15-n)
    localparam int ST_ERR = 15;
    localparam int ST_OVF = 14;
    localparam int ST_TRBL = 13;
    localparam int ST_INOP = 12;
    localparam int ST_BUSY = 8;
    localparam int ST_DRDY_N = 7;
    localparam int ST_HOPPER = 6;
    localparam int ST_HOLD = 3;
    localparam int ST_PICKF = 2;
    localparam logic [15:0] STATUS_RST = 16'h8080;
    // command word positions
    localparam int CW_DI_CONN = 13;
    localparam int CW_SI_CONN = 12;
    localparam int CW_EOB = 11;
    localparam int CW_MODE = 10;
    localparam int CW_TERM = 10;
    typedef enum logic [1:0] {PCR_CMD_NONE, PCR_CMD_INIT, PCR_CMD_TERM, PCR_CMD_NOOP} pcr_cmd_t;
endpackage : pcr_pkg

// ---- pcr_sync.sv ----
// two-flop synchroniser for reader pins
// assumes pins are low-true, so reset loads the inactive level
`timescale 1ns/100ps
module pcr_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pcr_sync

// ---- pcr_xlate.sv ----
// twelve-row punch pattern to eight-bit translate code
// assumes row order 12,11,0,1..9 at index 0..11, active high
`timescale 1ns/100ps
module pcr_xlate (
    input wire logic [11:0] rows,
    output logic [7:0] code
);
    always_comb begin
        code = 8'h00;
        code[7] = rows[0];
        code[6] = rows[1];
        code[5] = rows[2];
        // only one of rows 1..7 is punched; highest wins if not
        for (int i = 3; i <= 9; i++) begin
            if (rows[i]) begin
                code[4:2] = 3'(i - 2);
            end
        end
        code[1] = rows[10];
        code[0] = rows[11];
    end
endmodule : pcr_xlate

// ---- pcr_ctrl.sv ----
// register-mode punched card reader controller: commands, pick, column capture, status
// assumes decoded host strobes on clock, reader pins asynchronous and low-true
`timescale 1ns/100ps
module pcr_ctrl #(
    parameter int PICK_CYC = pcr_pkg::PICK_MIN_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic initiate_cmd,
    input wire logic terminate_cmd,
    input wire logic noop_cmd,
    input wire logic [15:0] cmd_word,
    input wire logic input_data_command,
    input wire logic card_at_read_station_n,
    input wire logic column_strobe_n,
    input wire logic [11:0] column_data_n,
    input wire logic reader_ready_n,
    input wire logic power_off_n,
    input wire logic pick_fail_n,
    input wire logic hopper_stacker_n,
    input wire logic read_check_n,
    input wire logic motion_check_n,
    input wire logic stop_button_n,
    input wire logic reset_button_n,
    output logic [15:0] reader_status_word,
    output logic [15:0] column_word,
    output logic column_data_request,
    output logic data_interrupt_request,
    output logic service_interrupt_request,
    output logic pick_request_line_n
);
    localparam int CW = $clog2(PICK_CYC + 1);

    // a zero count would release pick before the reader can latch it
    if (PICK_CYC < 1) begin : g_bad_pick
        $error("pick hold count must be at least one cycle");
    end

    logic [21:0] pins_s;
    logic card_in_reader, column_strobe, reader_ready, stop_btn, reset_btn;
    logic pwr_off, pick_fail, hopper, read_check, motion_check;
    logic [11:0] col_rows;
    logic card_d_r, strobe_d_r;
    logic card_fall, strobe_rise, buffer_load_strobe;
    logic read_trouble, inoperable;
    pcr_pkg::pcr_cmd_t pend_kind_r;
    logic [15:0] pend_word_r;
    logic go, inop_cmd, transfer_initiate_pulse, term_exec, noop_exec;
    logic terminate_idle_service_set;
    logic xfer_en_r, busy_r, pick_r, pick_nxt, mode_bin_r;
    logic [CW-1:0] pick_cnt_r;
    logic data_ready_r, ovf_r, si_req_r, hold_r;
    logic di_conn_r, si_conn_r;
    logic [11:0] buf_r;
    logic [7:0] xlate_code;
    logic req_nxt;

    pcr_sync #(
        .W(22)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .d({card_at_read_station_n, column_strobe_n, column_data_n, reader_ready_n, power_off_n,
            pick_fail_n, hopper_stacker_n, read_check_n, motion_check_n, stop_button_n, reset_button_n}),
        .q(pins_s)
    );

    assign card_in_reader = ~pins_s[21];
    assign column_strobe = ~pins_s[20];
    assign col_rows = ~pins_s[19:8];
    assign reader_ready = ~pins_s[7];
    assign pwr_off = ~pins_s[6];
    assign pick_fail = ~pins_s[5];
    assign hopper = ~pins_s[4];
    assign read_check = ~pins_s[3];
    assign motion_check = ~pins_s[2];
    assign stop_btn = ~pins_s[1];
    assign reset_btn = ~pins_s[0];

    assign read_trouble = read_check | motion_check;
    assign inoperable = pwr_off | pick_fail | hopper | read_trouble;

    // edge detectors on synchronised reader lines
    always_ff @(posedge clock) begin
        if (srst) begin
            card_d_r <= 1'b0;
            strobe_d_r <= 1'b0;
        end else begin
            card_d_r <= card_in_reader;
            strobe_d_r <= column_strobe;
        end
    end

    assign card_fall = card_d_r & ~card_in_reader;
    assign strobe_rise = ~strobe_d_r & column_strobe;
    // one load per strobe trailing edge; relies on the reader spacing strobes
    assign buffer_load_strobe = strobe_d_r & ~column_strobe;

    // hold: stop pressed on an operable reader, released by reset button
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_r <= 1'b0;
        end else if (stop_btn && !inoperable) begin
            hold_r <= 1'b1;
        end else if (reset_btn) begin
            hold_r <= 1'b0;
        end
    end

    // every command is parked here; it runs once hold is gone
    always_ff @(posedge clock) begin
        if (srst) begin
            pend_kind_r <= pcr_pkg::PCR_CMD_NONE;
            pend_word_r <= 16'h0000;
        end else if (initiate_cmd || terminate_cmd || noop_cmd) begin
            pend_kind_r <= initiate_cmd ? pcr_pkg::PCR_CMD_INIT :
                           terminate_cmd ? pcr_pkg::PCR_CMD_TERM : pcr_pkg::PCR_CMD_NOOP;
            pend_word_r <= cmd_word;
        end else if (go && (inoperable || pend_kind_r != pcr_pkg::PCR_CMD_INIT || reader_ready)) begin
            pend_kind_r <= pcr_pkg::PCR_CMD_NONE;
        end
    end

    assign go = (pend_kind_r != pcr_pkg::PCR_CMD_NONE) && !hold_r;
    assign inop_cmd = go && inoperable;
    // initiate waits for ready rather than being dropped
    assign transfer_initiate_pulse = go && !inoperable && reader_ready &&
                                     pend_kind_r == pcr_pkg::PCR_CMD_INIT;
    assign term_exec = go && !inoperable && pend_kind_r == pcr_pkg::PCR_CMD_TERM &&
                       pend_word_r[pcr_pkg::CW_TERM];
    assign noop_exec = go && !inoperable && pend_kind_r == pcr_pkg::PCR_CMD_NOOP;
    assign terminate_idle_service_set = term_exec && !busy_r;

    // interrupt connections from the initiate or no-op word
    always_ff @(posedge clock) begin
        if (srst) begin
            di_conn_r <= 1'b0;
            si_conn_r <= 1'b0;
        end else if (transfer_initiate_pulse || noop_exec) begin
            di_conn_r <= pend_word_r[pcr_pkg::CW_DI_CONN];
            si_conn_r <= pend_word_r[pcr_pkg::CW_SI_CONN];
        end
    end

    // control flops: initiate sets both; service request clears both, terminate clears enable, card end clears busy
    always_ff @(posedge clock) begin
        if (srst) begin
            xfer_en_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (transfer_initiate_pulse) begin
            xfer_en_r <= 1'b1;
            busy_r <= 1'b1;
        end else begin
            if (term_exec || si_req_r) begin
                xfer_en_r <= 1'b0;
            end
            if (card_fall || si_req_r) begin
                busy_r <= 1'b0;
            end
        end
    end

    // pick stays until card arrives and the minimum hold with ready has passed
    always_comb begin
        pick_nxt = pick_r;
        if (transfer_initiate_pulse) begin
            pick_nxt = 1'b1;
        end else if (si_req_r) begin
            pick_nxt = 1'b0;
        end else if (card_in_reader && pick_cnt_r == CW'(PICK_CYC)) begin
            pick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pick_r <= 1'b0;
            pick_request_line_n <= 1'b1;
            pick_cnt_r <= '0;
        end else begin
            pick_r <= pick_nxt;
            pick_request_line_n <= ~pick_nxt;
            if (transfer_initiate_pulse) begin
                pick_cnt_r <= '0;
            end else if (pick_r && reader_ready && pick_cnt_r != CW'(PICK_CYC)) begin
                pick_cnt_r <= pick_cnt_r + 1'b1;
            end
        end
    end

    // mode latch
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_bin_r <= 1'b0;
        end else if (transfer_initiate_pulse) begin
            mode_bin_r <= pend_word_r[pcr_pkg::CW_MODE];
        end else if (si_req_r) begin
            mode_bin_r <= 1'b0;
        end
    end

    // data ready and overflow; a new event wins over the host's take
    always_ff @(posedge clock) begin
        if (srst || !busy_r) begin
            data_ready_r <= 1'b0;
        end else if (buffer_load_strobe && xfer_en_r) begin
            data_ready_r <= 1'b1;
        end else if (input_data_command) begin
            data_ready_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ovf_r <= 1'b0;
        end else if ((strobe_rise || card_fall) && data_ready_r) begin
            ovf_r <= 1'b1;
        end else if (input_data_command) begin
            ovf_r <= 1'b0;
        end
    end

    assign req_nxt = data_ready_r && xfer_en_r && !ovf_r && !term_exec;

    // stored data interrupt request, cleared by data take, terminate without end-of-block, or disconnect
    always_ff @(posedge clock) begin
        if (srst) begin
            column_data_request <= 1'b0;
            data_interrupt_request <= 1'b0;
        end else begin
            column_data_request <= req_nxt;
            if (di_conn_r && ((req_nxt && !column_data_request) ||
                              (term_exec && pend_word_r[pcr_pkg::CW_EOB]))) begin
                data_interrupt_request <= 1'b1;
            end else if (input_data_command || term_exec ||
                         ((transfer_initiate_pulse || noop_exec) && !pend_word_r[pcr_pkg::CW_DI_CONN])) begin
                data_interrupt_request <= 1'b0;
            end
        end
    end

    // service request: card end, command while inoperable, terminate while idle
    always_ff @(posedge clock) begin
        if (srst) begin
            si_req_r <= 1'b0;
            service_interrupt_request <= 1'b0;
        end else begin
            if (card_fall || inop_cmd || terminate_idle_service_set) begin
                si_req_r <= 1'b1;
            end else if (transfer_initiate_pulse || noop_exec) begin
                si_req_r <= 1'b0;
            end
            service_interrupt_request <= si_req_r && si_conn_r;
        end
    end

    // column buffer and output formatting
    always_ff @(posedge clock) begin
        if (srst) begin
            buf_r <= 12'h000;
        end else if (buffer_load_strobe) begin
            buf_r <= col_rows;
        end
    end

    pcr_xlate u_xlate (
        .rows(buf_r),
        .code(xlate_code)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            column_word <= 16'h0000;
        end else if (mode_bin_r) begin
            column_word <= {4'h0, buf_r};
        end else begin
            column_word <= {8'h00, xlate_code};
        end
    end

    // status word refreshed every cycle; unused positions stay zero
    always_ff @(posedge clock) begin
        if (srst) begin
            reader_status_word <= pcr_pkg::STATUS_RST;
        end else begin
            reader_status_word <= 16'h0000;
            reader_status_word[pcr_pkg::ST_ERR] <= !(ovf_r || read_trouble || inoperable);
            reader_status_word[pcr_pkg::ST_OVF] <= ovf_r;
            reader_status_word[pcr_pkg::ST_TRBL] <= read_trouble;
            reader_status_word[pcr_pkg::ST_INOP] <= inoperable;
            reader_status_word[pcr_pkg::ST_BUSY] <= busy_r;
            reader_status_word[pcr_pkg::ST_DRDY_N] <= !data_ready_r;
            reader_status_word[pcr_pkg::ST_HOPPER] <= hopper;
            reader_status_word[pcr_pkg::ST_HOLD] <= hold_r;
            reader_status_word[pcr_pkg::ST_PICKF] <= pick_fail;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_err_summary: assert property (reader_status_word[15] == !(|reader_status_word[14:12]))
        else $error("error summary bit disagrees");
    chk_inop_status: assert property ($rose(inoperable) |=> reader_status_word[12])
        else $error("inoperable not reported");
    chk_ready_gate: assert property (transfer_initiate_pulse |-> reader_ready && !hold_r)
        else $error("pick accepted while not ready");
    chk_init_sets: assert property (transfer_initiate_pulse |=> xfer_en_r && busy_r && !pick_request_line_n)
        else $error("initiate did not set control flops");
    chk_pick_min: assert property ($fell(pick_r) && !$past(si_req_r) |-> $past(pick_cnt_r) == CW'(PICK_CYC))
        else $error("pick dropped before minimum time");
    chk_idle_drdy: assert property (!busy_r |=> !data_ready_r)
        else $error("data ready set while idle");
    chk_req_cause: assert property (column_data_request |-> $past(data_ready_r && xfer_en_r && !ovf_r))
        else $error("data request without cause");
    chk_ovf_set: assert property (strobe_rise && data_ready_r |=> ovf_r ##1 reader_status_word[14])
        else $error("overflow missed");
    chk_ovf_stick: assert property (ovf_r && !input_data_command |=> ovf_r && !column_data_request)
        else $error("overflow lost or request leaked");
    chk_buf_load: assert property (buffer_load_strobe |=> buf_r == $past(col_rows))
        else $error("column not captured");
    chk_mode_clear: assert property (si_req_r && !transfer_initiate_pulse |=> !mode_bin_r && !busy_r)
        else $error("service did not reset mode");
    chk_card_end_si: assert property (card_fall |=> si_req_r)
        else $error("card end gave no service request");

    cov_card_read: cover property (transfer_initiate_pulse ##[1:1000] card_fall);
    cov_overflow: cover property ($rose(ovf_r));
    cov_hold_cmd: cover property (hold_r && pend_kind_r != pcr_pkg::PCR_CMD_NONE ##[1:100] !hold_r);
endmodule : pcr_ctrl

// ---- pcr_reader_model.sv ----
// card reader mechanism model: run-up, pick, one card of column strobes
// assumes the bench supplies the rows and column count; all pins low-true
`timescale 1ns/100ps
module pcr_reader_model #(
    parameter int PICK_CYC = 4,
    parameter int RUNUP = 20,
    parameter int GAP = 40
) (
    input wire logic clock,
    input wire logic pick_request_line_n,
    input wire logic [7:0] ncols,
    input wire logic [11:0] rows,
    output logic reader_ready_n,
    output logic card_at_read_station_n,
    output logic column_strobe_n,
    output logic [11:0] column_data_n
);
    int held;
    // data lines wander between strobes, so a late capture sees garbage
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clock);
            column_data_n = ~column_data_n;
        end
    endtask : idle
    initial begin
        reader_ready_n = 1'b1;
        card_at_read_station_n = 1'b1;
        column_strobe_n = 1'b1;
        column_data_n = 12'h000;
        idle(RUNUP);
        reader_ready_n = 1'b0;
        forever begin
            held = 0;
            while (held < PICK_CYC) begin
                @(negedge clock);
                held = (!pick_request_line_n && !reader_ready_n) ? held + 1 : 0;
            end
            card_at_read_station_n = 1'b0;
            for (int c = 0; c < ncols; c++) begin
                idle(GAP);
                column_data_n = ~rows;
                @(negedge clock);
                column_strobe_n = 1'b0;
                repeat (6) @(negedge clock);
                column_strobe_n = 1'b1;
                @(negedge clock);
            end
            idle(GAP);
            card_at_read_station_n = 1'b1;
        end
    end
endmodule : pcr_reader_model

// ---- pcr_ctrl_tb.sv ----
// self-checking bench for the card reader controller
// assumes pcr_pkg and the reader model; short pick count for speed
`timescale 1ns/100ps
module pcr_ctrl_tb;
    localparam int PCYC = 4;
    logic clock;
    logic srst, initiate_cmd, terminate_cmd, noop_cmd, input_data_command;
    logic stop_button_n, reset_button_n;
    logic [15:0] cmd_word;
    logic [4:0] fault_n;
    logic [7:0] ncols;
    logic [11:0] rows, column_data_n;
    logic [31:0] seed;
    logic [15:0] reader_status_word, column_word;
    logic column_data_request, data_interrupt_request, service_interrupt_request;
    logic pick_request_line_n, reader_ready_n, card_at_read_station_n, column_strobe_n;
    wire [18:0] obs = {column_data_request, pick_request_line_n, service_interrupt_request, reader_status_word};
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_req = 0;
    int req_base = 0;

    pcr_ctrl #(.PICK_CYC(PCYC)) dut (
        .clock(clock), .srst(srst), .initiate_cmd(initiate_cmd), .terminate_cmd(terminate_cmd),
        .noop_cmd(noop_cmd), .cmd_word(cmd_word), .input_data_command(input_data_command),
        .card_at_read_station_n(card_at_read_station_n), .column_strobe_n(column_strobe_n),
        .column_data_n(column_data_n), .reader_ready_n(reader_ready_n), .power_off_n(fault_n[0]),
        .pick_fail_n(fault_n[1]), .hopper_stacker_n(fault_n[2]), .read_check_n(fault_n[3]),
        .motion_check_n(fault_n[4]), .stop_button_n(stop_button_n), .reset_button_n(reset_button_n),
        .reader_status_word(reader_status_word), .column_word(column_word),
        .column_data_request(column_data_request), .data_interrupt_request(data_interrupt_request),
        .service_interrupt_request(service_interrupt_request), .pick_request_line_n(pick_request_line_n)
    );
    pcr_reader_model #(.PICK_CYC(PCYC)) u_reader (
        .clock(clock), .pick_request_line_n(pick_request_line_n), .ncols(ncols), .rows(rows),
        .reader_ready_n(reader_ready_n), .card_at_read_station_n(card_at_read_station_n),
        .column_strobe_n(column_strobe_n), .column_data_n(column_data_n)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard, well above the few thousand cycles the cards take
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (column_data_request === 1'b1) n_req <= n_req + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_bit(input string what, input int i, input logic v);
        int n;
        n = 0;
        while (obs[i] !== v && n < 3000) begin
            @(negedge clock);
            n++;
        end
        check(what, {15'h0, obs[i]}, {15'h0, v});
    endtask : wait_bit

    task automatic cmd(input int k, input logic [15:0] w);
        cmd_word = w;
        initiate_cmd = (k == 0);
        terminate_cmd = (k == 1);
        noop_cmd = (k == 2);
        @(negedge clock);
        {initiate_cmd, terminate_cmd, noop_cmd} = 3'b000;
        @(negedge clock);
    endtask : cmd

    task automatic take();
        input_data_command = 1'b1;
        @(negedge clock);
        input_data_command = 1'b0;
        wait_bit("req", 18, 1'b0);
    endtask : take

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // printed status bit n
    function automatic logic [15:0] st(input int n);
        return 16'h8000 >> n;
    endfunction : st

    function automatic logic [7:0] xlat(input logic [11:0] r);
        logic [2:0] n;
        n = 3'h0;
        for (int k = 0; k < 7; k++) if (r[3 + k]) n = 3'(k + 1);
        return {r[0], r[1], r[2], n, r[10], r[11]};
    endfunction : xlat

    function automatic logic [15:0] fault_bits(input int f);
        case (f)
            1: return st(13);
            2: return st(9);
            3, 4: return st(2);
            default: return 16'h0000;
        endcase
    endfunction : fault_bits

    initial begin
        seed = 32'h0000_f4d0;
        srst = 1'b1;
        {initiate_cmd, terminate_cmd, noop_cmd, input_data_command} = 4'h0;
        {stop_button_n, reset_button_n} = 2'b11;
        fault_n = 5'h1f;
        cmd_word = 16'h0000;
        ncols = 8'h50;
        rows = 12'h000;
        repeat (10) @(negedge clock);
        srst = 1'b0;
        repeat (2) @(negedge clock);
        check("status", reader_status_word, st(0) | st(8));
        check("pick", {15'h0, pick_request_line_n}, 16'h0001);
        check("column", column_word, 16'h0000);
        // binary card, full 80 columns, both interrupts connected
        cmd(0, 16'hbc00);
        wait_bit("pick", 17, 1'b0);
        // status word trails the busy flop by one cycle
        @(negedge clock);
        check("busy", reader_status_word & st(7), st(7));
        for (int c = 0; c < 80; c++) begin
            seed = lfsr(seed);
            rows = seed[11:0];
            wait_bit("req", 18, 1'b1);
            check("column", column_word, {4'h0, rows});
            check("dirq", {15'h0, data_interrupt_request}, 16'h0001);
            check("drdy", reader_status_word & st(8), 16'h0000);
            check("pick", {15'h0, pick_request_line_n}, 16'h0001);
            take();
        end
        wait_bit("sirq", 16, 1'b1);
        check("idle", reader_status_word & (st(7) | st(8)), st(8));
        cmd(2, 16'h3000);
        wait_bit("sirq", 16, 1'b0);
        // translate card, second column left unread
        ncols = 8'h03;
        cmd(0, 16'hb800);
        seed = lfsr(seed);
        rows = seed[11:0];
        rows[9:3] = (seed[14:12] == 3'h7) ? 7'h00 : 7'h01 << seed[14:12];
        wait_bit("req", 18, 1'b1);
        check("xlate", column_word, {8'h00, xlat(rows)});
        take();
        wait_bit("req", 18, 1'b1);
        // third strobe arrives with the second column still unread
        wait_bit("req", 18, 1'b0);
        wait_bit("sirq", 16, 1'b1);
        check("ovf", reader_status_word & (st(0) | st(1)), st(1));
        check("req", {15'h0, column_data_request}, 16'h0000);
        input_data_command = 1'b1;
        @(negedge clock);
        input_data_command = 1'b0;
        wait_bit("ovf", 15 - 1, 1'b0);
        wait_bit("err", 15, 1'b1);
        cmd(2, 16'h3000);
        wait_bit("sirq", 16, 1'b0);
        cmd(1, 16'h4400);
        wait_bit("sirq", 16, 1'b1);
        cmd(2, 16'h3000);
        wait_bit("sirq", 16, 1'b0);
        // hold parks the command until the reset control
        stop_button_n = 1'b0;
        wait_bit("hold", 15 - 12, 1'b1);
        ncols = 8'h03;
        cmd(0, 16'hbc00);
        repeat (20) @(negedge clock);
        check("pick", {15'h0, pick_request_line_n}, 16'h0001);
        stop_button_n = 1'b1;
        reset_button_n = 1'b0;
        wait_bit("pick", 17, 1'b0);
        reset_button_n = 1'b1;
        req_base = n_req;
        cmd(1, 16'h4400);
        wait_bit("sirq", 16, 1'b1);
        check("req", 16'(n_req - req_base), 16'h0000);
        cmd(2, 16'h3000);
        wait_bit("sirq", 16, 1'b0);
        // each reader fault in turn, with a command refused meanwhile
        for (int f = 0; f < 5; f++) begin
            fault_n[f] = 1'b0;
            wait_bit("inop", 15 - 3, 1'b1);
            check("status", reader_status_word, st(3) | st(8) | fault_bits(f));
            cmd(2, 16'h3000);
            wait_bit("sirq", 16, 1'b1);
            fault_n[f] = 1'b1;
            wait_bit("inop", 15 - 3, 1'b0);
            cmd(2, 16'h3000);
            wait_bit("sirq", 16, 1'b0);
        end
        summarize();
    end
endmodule : pcr_ctrl_tb
